/* core/cncfg_pkg.sv */
// Constants and types of the node configuration and status register bank
package cncfg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register addresses
    localparam logic [23:0] ADDR_NODE_PARAM_COUNT = 24'h10_0050;
    localparam logic [23:0] ADDR_STATION_IDENTIFIER = 24'h10_0054;
    localparam logic [23:0] ADDR_STATION_FILTER = 24'h10_0058;
    localparam logic [23:0] ADDR_SDO_SERVER_COUNT = 24'h10_0130;
    localparam logic [23:0] ADDR_SDO_REQUEST_ID = 24'h10_0134;
    localparam logic [23:0] ADDR_SDO_RESPONSE_ID = 24'h10_0138;
    localparam logic [23:0] ADDR_PART_CODE = 24'h10_0224;
    localparam logic [23:0] ADDR_REVISION = 24'h10_0228;
    localparam logic [23:0] ADDR_SERIAL = 24'h10_022c;
    localparam logic [23:0] ADDR_REDUNDANCY_COUNT = 24'h10_023c;
    localparam logic [23:0] ADDR_DEFAULT_LINK = 24'h10_0240;
    localparam logic [23:0] ADDR_SWITCH_PERIOD = 24'h10_0244;
    localparam logic [23:0] ADDR_SWITCH_LIMIT = 24'h10_0248;
    localparam logic [23:0] ADDR_SWITCH_COUNTER = 24'h10_024c;
    localparam logic [23:0] ADDR_CORE_CFG_COUNT = 24'h10_035c;
    localparam logic [23:0] ADDR_BIT_TIMING = 24'h10_0360;
    localparam logic [23:0] ADDR_STATUS = 24'h10_0364;
    localparam logic [23:0] ADDR_LAST_ABORT = 24'h10_0368;

    ////////////////////////////////////////////////////////////////////////
    // Fixed values
    localparam logic [7:0] NODE_PARAM_COUNT_VAL = 8'h02;
    localparam logic [7:0] SDO_SERVER_COUNT_VAL = 8'h02;
    localparam logic [7:0] REDUNDANCY_COUNT_VAL = 8'h04;
    localparam logic [7:0] CORE_CFG_COUNT_VAL = 8'h10;
    localparam logic [31:0] SDO_REQUEST_BASE = 32'h0000_0600;
    localparam logic [31:0] SDO_RESPONSE_BASE = 32'h0000_0580;
    localparam logic [31:0] PART_CODE_VAL = 32'h0000_1234; // Arbitrary value
    localparam logic [31:0] REVISION_VAL = 32'h0000_0a5a; // Arbitrary value
    localparam logic [31:0] SERIAL_VAL = 32'h0000_0c3c; // Arbitrary value

    ////////////////////////////////////////////////////////////////////////
    // Build-time reset values, bit positions and station filter mask
    localparam logic DEFAULT_LINK_RST = 1'b0;
    localparam logic [7:0] SWITCH_PERIOD_RST = 8'h10;
    localparam logic [7:0] SWITCH_LIMIT_RST = 8'h03;
    localparam logic [1:0] BIT_PRESCALER_RST = 2'h0;
    localparam logic [3:0] PHASE_SEG_ONE_RST = 4'h5;
    localparam logic [3:0] PHASE_SEG_TWO_RST = 4'h4;
    localparam logic [2:0] RESYNC_JUMP_RST = 3'h1;
    localparam logic AUTO_OPERATIONAL_RST = 1'b0;
    localparam int DEFAULT_LINK_BIT = 1;
    localparam int ACTIVE_LINK_BIT = 6;
    localparam int QUEUE_FULL_BIT = 7;
    localparam int CAN_RESET_BIT = 13;
    localparam int ERR_PASSIVE_BIT = 9;
    localparam int BUS_OFF_BIT = 10;
    localparam int AUTO_OPERATIONAL_FLAG_BIT = 11;
    localparam logic [7:0] STATION_FILTER_MASK = 8'h7f;

    ////////////////////////////////////////////////////////////////////////
    // Abort codes
    localparam logic [31:0] ABORT_TOGGLE = 32'h0503_0000;
    localparam logic [31:0] ABORT_COMMAND = 32'h0504_0001;
    localparam logic [31:0] ABORT_BLOCK_SIZE = 32'h0504_0002;
    localparam logic [31:0] ABORT_SEQUENCE = 32'h0504_0003;
    localparam logic [31:0] ABORT_READ_ONLY = 32'h0601_0002;
    localparam logic [31:0] ABORT_LENGTH = 32'h0607_0010;
    localparam logic [31:0] ABORT_SUBINDEX = 32'h0609_0011;
    localparam logic [31:0] ABORT_GENERAL = 32'h0800_0000;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        CNCFG_AB_TOGGLE = 3'd0,
        CNCFG_AB_COMMAND = 3'd1,
        CNCFG_AB_BLOCK = 3'd2,
        CNCFG_AB_SEQUENCE = 3'd3,
        CNCFG_AB_READ_ONLY = 3'd4,
        CNCFG_AB_LENGTH = 3'd5,
        CNCFG_AB_SUBINDEX = 3'd6,
        CNCFG_AB_GENERAL = 3'd7
    } cncfg_abort_e;

    typedef enum logic [5:0] {
        CNCFG_ST_NONE = 6'b00_0000,
        CNCFG_ST_INIT = 6'b00_0001,
        CNCFG_ST_RST_APP = 6'b00_0010,
        CNCFG_ST_RST_COMM = 6'b00_0100,
        CNCFG_ST_PREOP = 6'b00_1000,
        CNCFG_ST_OPER = 6'b01_0000,
        CNCFG_ST_STOP = 6'b10_0000
    } cncfg_nmt_e;

    typedef struct packed {
        logic req;
        logic wr;
        logic [23:0] addr;
        logic [31:0] wdata;
    } cncfg_acc_s;

    typedef struct packed {
        logic [2:0] resync_jump_width;
        logic [3:0] phase_seg_two;
        logic [3:0] phase_seg_one;
        logic [1:0] bit_prescaler;
    } cncfg_timing_s;

    typedef struct packed {
        logic [7:0] tx_err_cnt;
        logic [7:0] rx_err_cnt;
        logic err_passive;
        logic bus_off;
    } cncfg_can_s;

    typedef struct packed {
        logic [7:0] station;
        logic [7:0] filter;
        logic [7:0] switch_period;
        logic [7:0] switch_limit;
        logic [7:0] switch_counter;
        cncfg_timing_s timing;
        logic can_reset;
        logic active_link;
        logic queue_full;
        logic auto_operational_flag;
        cncfg_nmt_e nmt;
        logic [31:0] last_abort;
        logic [31:0] host_rdata;
        logic [31:0] sdo_rdata;
        logic host_ack;
        logic sdo_ack;
        logic sdo_abort;
        logic [31:0] sdo_abort_code;
        logic id_taken;
    } cncfg_state_s;

endpackage

/* core/cncfg_regs.sv */
// Configuration and status register bank of the node controller
`timescale 1ns/100ps
`default_nettype none
module cncfg_regs (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Identifier pins and strap
    input wire logic [7:0] station_pins_i,
    input wire logic default_link_i,
    // Host access port
    input wire cncfg_pkg::cncfg_acc_s host_acc_i,
    output logic [31:0] host_rdata_o,
    output logic host_ack_o,
    // SDO server access port
    input wire cncfg_pkg::cncfg_acc_s sdo_acc_i,
    output logic [31:0] sdo_rdata_o,
    output logic sdo_ack_o,
    output logic sdo_abort_o,
    output logic [31:0] sdo_abort_code_o,
    // Protocol engine events
    input wire logic sdo_fault_i,
    input wire cncfg_pkg::cncfg_abort_e sdo_fault_kind_i,
    input wire logic abort_rx_i,
    input wire logic [31:0] abort_rx_code_i,
    input wire logic nmt_set_i,
    input wire cncfg_pkg::cncfg_nmt_e nmt_state_i,
    input wire logic init_done_i,
    input wire logic queue_overflow_i,
    input wire logic link_switch_i,
    // CAN core side
    input wire cncfg_pkg::cncfg_can_s can_i,
    output cncfg_pkg::cncfg_timing_s timing_o,
    output logic can_reset_o,
    output logic active_link_o,
    output logic can_err_o,
    output cncfg_pkg::cncfg_nmt_e nmt_state_o,
    output logic [7:0] switch_period_o,
    output logic [7:0] switch_limit_o
);

    cncfg_pkg::cncfg_state_s st_r;
    cncfg_pkg::cncfg_state_s st_nxt;
    logic [31:0] host_view;
    logic [31:0] sdo_view;
    logic host_hit;
    logic sdo_hit;
    logic sdo_rc_hit;
    logic host_rc_hit;
    logic host_go;
    logic sdo_go;
    logic host_wr;
    logic sdo_wr;
    logic sdo_rw_addr;
    logic sdo_ro_wr;
    logic [31:0] fault_code;

    ////////////////////////////////////////////////////////////////////////
    // State after reset
    localparam cncfg_pkg::cncfg_state_s ST_RST = '{
        station: 8'h00,
        filter: 8'h00,
        switch_period: cncfg_pkg::SWITCH_PERIOD_RST,
        switch_limit: cncfg_pkg::SWITCH_LIMIT_RST,
        switch_counter: 8'h00,
        timing: {cncfg_pkg::RESYNC_JUMP_RST, cncfg_pkg::PHASE_SEG_TWO_RST,
            cncfg_pkg::PHASE_SEG_ONE_RST, cncfg_pkg::BIT_PRESCALER_RST},
        can_reset: 1'b1,
        active_link: 1'b0,
        queue_full: 1'b0,
        auto_operational_flag: cncfg_pkg::AUTO_OPERATIONAL_RST,
        nmt: cncfg_pkg::CNCFG_ST_NONE,
        last_abort: 32'h0000_0000,
        host_rdata: 32'h0000_0000,
        sdo_rdata: 32'h0000_0000,
        host_ack: 1'b0,
        sdo_ack: 1'b0,
        sdo_abort: 1'b0,
        sdo_abort_code: 32'h0000_0000,
        id_taken: 1'b0
    };

    ////////////////////////////////////////////////////////////////////////
    // Read mux shared by both ports
    function automatic logic [32:0] read_reg(
        input cncfg_pkg::cncfg_state_s s,
        input logic dlink,
        input cncfg_pkg::cncfg_can_s c,
        input logic [23:0] a
    );
        logic [31:0] d;
        logic hit;
        d = 32'h0000_0000;
        hit = 1'b1;
        unique case (a)
            cncfg_pkg::ADDR_NODE_PARAM_COUNT:
                d[7:0] = cncfg_pkg::NODE_PARAM_COUNT_VAL;
            cncfg_pkg::ADDR_SDO_SERVER_COUNT:
                d[7:0] = cncfg_pkg::SDO_SERVER_COUNT_VAL;
            cncfg_pkg::ADDR_REDUNDANCY_COUNT:
                d[7:0] = cncfg_pkg::REDUNDANCY_COUNT_VAL;
            cncfg_pkg::ADDR_CORE_CFG_COUNT:
                d[7:0] = cncfg_pkg::CORE_CFG_COUNT_VAL;
            cncfg_pkg::ADDR_STATION_IDENTIFIER: d[7:0] = s.station;
            cncfg_pkg::ADDR_STATION_FILTER: d[7:0] = s.filter;
            cncfg_pkg::ADDR_SDO_REQUEST_ID:
                d = cncfg_pkg::SDO_REQUEST_BASE + {24'h00_0000, s.station};
            cncfg_pkg::ADDR_SDO_RESPONSE_ID:
                d = cncfg_pkg::SDO_RESPONSE_BASE + {24'h00_0000, s.station};
            cncfg_pkg::ADDR_PART_CODE: d = cncfg_pkg::PART_CODE_VAL;
            cncfg_pkg::ADDR_REVISION: d = cncfg_pkg::REVISION_VAL;
            cncfg_pkg::ADDR_SERIAL: d = cncfg_pkg::SERIAL_VAL;
            cncfg_pkg::ADDR_DEFAULT_LINK:
                d[cncfg_pkg::DEFAULT_LINK_BIT] = dlink;
            cncfg_pkg::ADDR_SWITCH_PERIOD: d[7:0] = s.switch_period;
            cncfg_pkg::ADDR_SWITCH_LIMIT: d[7:0] = s.switch_limit;
            cncfg_pkg::ADDR_SWITCH_COUNTER: d[7:0] = s.switch_counter;
            cncfg_pkg::ADDR_BIT_TIMING: begin
                d[12:0] = s.timing;
                d[cncfg_pkg::CAN_RESET_BIT] = s.can_reset;
            end
            cncfg_pkg::ADDR_STATUS: begin
                d[5:0] = s.nmt;
                d[cncfg_pkg::ACTIVE_LINK_BIT] = s.active_link;
                d[cncfg_pkg::QUEUE_FULL_BIT] = s.queue_full;
                d[cncfg_pkg::ERR_PASSIVE_BIT] = c.err_passive;
                d[cncfg_pkg::BUS_OFF_BIT] = c.bus_off;
                d[cncfg_pkg::AUTO_OPERATIONAL_FLAG_BIT] = s.auto_operational_flag;
                d[23:16] = c.rx_err_cnt;
                d[31:24] = c.tx_err_cnt;
            end
            cncfg_pkg::ADDR_LAST_ABORT: d = s.last_abort;
            default: hit = 1'b0;
        endcase
        return {hit, d};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Abort code for each fault kind of the SDO server
    function automatic logic [31:0] abort_value(
        input cncfg_pkg::cncfg_abort_e k
    );
        logic [31:0] v;
        v = cncfg_pkg::ABORT_GENERAL;
        unique case (k)
            cncfg_pkg::CNCFG_AB_TOGGLE: v = cncfg_pkg::ABORT_TOGGLE;
            cncfg_pkg::CNCFG_AB_GENERAL: v = cncfg_pkg::ABORT_GENERAL;
            cncfg_pkg::CNCFG_AB_COMMAND: v = cncfg_pkg::ABORT_COMMAND;
            cncfg_pkg::CNCFG_AB_BLOCK: v = cncfg_pkg::ABORT_BLOCK_SIZE;
            cncfg_pkg::CNCFG_AB_SEQUENCE: v = cncfg_pkg::ABORT_SEQUENCE;
            cncfg_pkg::CNCFG_AB_READ_ONLY: v = cncfg_pkg::ABORT_READ_ONLY;
            cncfg_pkg::CNCFG_AB_LENGTH: v = cncfg_pkg::ABORT_LENGTH;
            cncfg_pkg::CNCFG_AB_SUBINDEX: v = cncfg_pkg::ABORT_SUBINDEX;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Access decode; go is masked while ack is high, so a held request acts every other cycle
    assign host_go = host_acc_i.req & ~st_r.host_ack;
    assign sdo_go = sdo_acc_i.req & ~st_r.sdo_ack;
    assign host_wr = host_go & host_acc_i.wr;
    assign sdo_wr = sdo_go & sdo_acc_i.wr;

    // Read views of both ports
    assign {host_hit, host_view} = read_reg(st_r, default_link_i, can_i,
        host_acc_i.addr);
    assign {sdo_hit, sdo_view} = read_reg(st_r, default_link_i, can_i,
        sdo_acc_i.addr);

    assign host_rc_hit = host_go
        & (host_acc_i.addr == cncfg_pkg::ADDR_SWITCH_COUNTER);
    assign sdo_rc_hit = sdo_go
        & (sdo_acc_i.addr == cncfg_pkg::ADDR_SWITCH_COUNTER);

    // Only the redundancy fields are writable over SDO
    assign sdo_rw_addr = (sdo_acc_i.addr == cncfg_pkg::ADDR_SWITCH_PERIOD)
        | (sdo_acc_i.addr == cncfg_pkg::ADDR_SWITCH_LIMIT)
        | (sdo_acc_i.addr == cncfg_pkg::ADDR_SWITCH_COUNTER);
    assign sdo_ro_wr = sdo_wr & sdo_hit & ~sdo_rw_addr;
    assign fault_code = abort_value(sdo_fault_kind_i);

    ////////////////////////////////////////////////////////////////////////
    // Next state of the whole bank
    always_comb begin
        st_nxt = st_r;
        st_nxt.host_ack = host_go;
        st_nxt.sdo_ack = sdo_go;
        st_nxt.sdo_abort = 1'b0;
        // Read data held until the next access
        if (host_go) begin
            st_nxt.host_rdata = host_view;
        end
        if (sdo_go) begin
            st_nxt.sdo_rdata = sdo_view;
        end
        if (!st_r.id_taken) begin
            st_nxt.station = station_pins_i;
            st_nxt.filter = station_pins_i & cncfg_pkg::STATION_FILTER_MASK;
            st_nxt.id_taken = 1'b1;
        end
        if (host_wr) begin
            if (host_acc_i.addr == cncfg_pkg::ADDR_SWITCH_PERIOD) begin
                st_nxt.switch_period = host_acc_i.wdata[7:0];
            end
            if (host_acc_i.addr == cncfg_pkg::ADDR_SWITCH_LIMIT) begin
                st_nxt.switch_limit = host_acc_i.wdata[7:0];
            end
            if (host_acc_i.addr == cncfg_pkg::ADDR_BIT_TIMING) begin
                st_nxt.timing = host_acc_i.wdata[12:0];
                st_nxt.can_reset = host_acc_i.wdata[cncfg_pkg::CAN_RESET_BIT];
            end
            if (host_acc_i.addr == cncfg_pkg::ADDR_STATUS) begin
                st_nxt.active_link =
                    host_acc_i.wdata[cncfg_pkg::ACTIVE_LINK_BIT];
                if (host_acc_i.wdata[cncfg_pkg::QUEUE_FULL_BIT]) begin
                    st_nxt.queue_full = 1'b0;
                end
            end
        end
        if (sdo_wr) begin
            if (sdo_acc_i.addr == cncfg_pkg::ADDR_SWITCH_PERIOD) begin
                st_nxt.switch_period = sdo_acc_i.wdata[7:0];
            end
            if (sdo_acc_i.addr == cncfg_pkg::ADDR_SWITCH_LIMIT) begin
                st_nxt.switch_limit = sdo_acc_i.wdata[7:0];
            end
        end
        // write or read only zeroes counter
        if (host_rc_hit | sdo_rc_hit) begin
            st_nxt.switch_counter = 8'h00;
        end
        // Bus switch counts and flips link, event wins
        if (link_switch_i) begin
            st_nxt.active_link = ~st_nxt.active_link;
            if (st_nxt.switch_counter != 8'hff) begin
                st_nxt.switch_counter = st_nxt.switch_counter + 8'h01;
            end
        end
        if (queue_overflow_i) begin
            st_nxt.queue_full = 1'b1;
        end
        if (nmt_set_i) begin
            st_nxt.nmt = nmt_state_i;
        end else if (init_done_i && st_r.auto_operational_flag) begin
            st_nxt.nmt = cncfg_pkg::CNCFG_ST_OPER;
        end
        if (sdo_fault_i) begin
            st_nxt.sdo_abort = 1'b1;
            st_nxt.sdo_abort_code = fault_code;
        end else if (sdo_go && !sdo_hit) begin
            st_nxt.sdo_abort = 1'b1;
            st_nxt.sdo_abort_code = cncfg_pkg::ABORT_SUBINDEX;
        end else if (sdo_ro_wr) begin
            st_nxt.sdo_abort = 1'b1;
            st_nxt.sdo_abort_code = cncfg_pkg::ABORT_READ_ONLY;
        end
        if (st_nxt.sdo_abort) begin
            st_nxt.last_abort = st_nxt.sdo_abort_code;
        end
        if (abort_rx_i) begin
            st_nxt.last_abort = abort_rx_code_i;
        end
    end

    // State register, asynchronous reset to constants
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign host_rdata_o = st_r.host_rdata;
    assign host_ack_o = st_r.host_ack;
    assign sdo_rdata_o = st_r.sdo_rdata;
    assign sdo_ack_o = st_r.sdo_ack;
    assign sdo_abort_o = st_r.sdo_abort;
    assign sdo_abort_code_o = st_r.sdo_abort_code;
    assign timing_o = st_r.timing;
    assign can_reset_o = st_r.can_reset;
    assign active_link_o = st_r.active_link;
    assign can_err_o = st_r.queue_full;
    assign nmt_state_o = st_r.nmt;
    assign switch_period_o = st_r.switch_period;
    assign switch_limit_o = st_r.switch_limit;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_req_id_read;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        sdo_go && !sdo_acc_i.wr
            && (sdo_acc_i.addr == cncfg_pkg::ADDR_SDO_REQUEST_ID)
        |=> sdo_rdata_o == (cncfg_pkg::SDO_REQUEST_BASE
            + {24'h00_0000, $past(st_r.station)});
    endproperty
    a_req_id_read: assert property (p_req_id_read)
        else $error("request identifier read wrong");
    property p_read_clears;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        host_rc_hit && !host_acc_i.wr && !link_switch_i
        |=> st_r.switch_counter == 8'h00;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("counter not cleared by read");
    property p_write_clears;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        sdo_rc_hit && sdo_acc_i.wr && !link_switch_i
        |=> st_r.switch_counter == 8'h00;
    endproperty
    a_write_clears: assert property (p_write_clears)
        else $error("counter not cleared by write");
    property p_sdo_timing_ro;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        sdo_wr && !host_wr
            && (sdo_acc_i.addr == cncfg_pkg::ADDR_BIT_TIMING)
        |=> $stable(timing_o) && $stable(can_reset_o);
    endproperty
    a_sdo_timing_ro: assert property (p_sdo_timing_ro)
        else $error("timing changed by SDO write");
    property p_queue_set;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        queue_overflow_i |=> can_err_o;
    endproperty
    a_queue_set: assert property (p_queue_set)
        else $error("queue overflow not flagged");
    property p_abort_rx;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        abort_rx_i |=> st_r.last_abort == $past(abort_rx_code_i);
    endproperty
    a_abort_rx: assert property (p_abort_rx)
        else $error("received abort code not kept");

endmodule
`default_nettype wire

/* tb/cncfg_can_model.sv */
// Behavioural model of the CAN core facing the register bank
`timescale 1ns/100ps
`default_nettype none
module cncfg_can_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Core reset from the register bank
    input wire logic can_reset_i,
    // Counter values set by the bench
    input wire logic [7:0] rx_set_i,
    input wire logic [7:0] tx_set_i,
    // Error state towards the register bank
    output cncfg_pkg::cncfg_can_s can_o
);
    // Counters cleared while the core is held in reset
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            can_o <= '0;
        end else if (can_reset_i) begin
            can_o <= '0;
        end else begin
            can_o.rx_err_cnt <= rx_set_i;
            can_o.tx_err_cnt <= tx_set_i;
            can_o.err_passive <= (rx_set_i[7] | tx_set_i[7]);
            can_o.bus_off <= (tx_set_i == 8'hff);
        end
    end
endmodule
`default_nettype wire

/* tb/test_canopen_node_config_status_regs.sv */
// Self-checking bench of the node configuration register bank
`timescale 1ns/100ps
`default_nettype none
module test_canopen_node_config_status_regs;
    logic clk = 0, rst_b = 0, ack, sack, fault = 0, arx = 0, nset = 0, lsw = 0;
    logic [31:0] q, hrd, srd, arc = '0;
    logic [7:0] rxs = '0, txs = '0;
    cncfg_pkg::cncfg_acc_s hacc = '0, sacc = '0;
    cncfg_pkg::cncfg_abort_e kind = cncfg_pkg::CNCFG_AB_TOGGLE;
    cncfg_pkg::cncfg_nmt_e nst = cncfg_pkg::CNCFG_ST_NONE;
    cncfg_pkg::cncfg_can_s can;
    logic crst, cerr, qov = 0;
    logic [31:0] codes [8] = '{32'h0503_0000, 32'h0504_0001, 32'h0504_0002,
        32'h0504_0003, 32'h0601_0002, 32'h0607_0010, 32'h0609_0011,
        32'h0800_0000};
    int err_count = 0, n_tests = 0;
    cncfg_regs dut_u (.core_clk_i(clk), .rst_b_i(rst_b),
        .station_pins_i(8'h15), .default_link_i(1'b0), .host_acc_i(hacc),
        .host_rdata_o(hrd), .host_ack_o(ack), .sdo_acc_i(sacc),
        .sdo_rdata_o(srd), .sdo_ack_o(sack), .sdo_abort_o(),
        .sdo_abort_code_o(), .sdo_fault_i(fault), .sdo_fault_kind_i(kind),
        .abort_rx_i(arx), .abort_rx_code_i(arc), .nmt_set_i(nset),
        .nmt_state_i(nst), .init_done_i(1'b0), .queue_overflow_i(qov),
        .link_switch_i(lsw), .can_i(can), .timing_o(), .can_reset_o(crst),
        .active_link_o(), .can_err_o(cerr), .nmt_state_o(),
        .switch_period_o(), .switch_limit_o());
    cncfg_can_model can_u (.core_clk_i(clk), .rst_b_i(rst_b),
        .can_reset_i(crst), .rx_set_i(rxs), .tx_set_i(txs), .can_o(can));
    initial forever #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    // Verdict and shared tasks
    task end_sim;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One access, request held until acknowledge
    task acc(input logic s, input logic w, input logic [23:0] a,
        input logic [31:0] d);
        int i;
        i = 0;
        if (s) sacc = {1'b1, w, a, d};
        else hacc = {1'b1, w, a, d};
        do begin
            @(posedge clk);
            i++;
        end while ((s ? sack : ack) !== 1'b1 && i < 20);
        q = s ? srd : hrd;
        if (i >= 20) begin
            err_count++;
            end_sim();
        end
        #1 sacc = '0;
        hacc = '0;
        // Idle cycle so the next request is seen as new
        @(posedge clk);
        #1;
    endtask
    task rd(input logic s, input logic [23:0] a, input logic [31:0] e);
        acc(s, 1'b0, a, '0);
        chk(q, e);
    endtask
    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(posedge clk);
        #1 sig = 1'b0;
        @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        #1 rst_b = 1;
        @(posedge clk);
        #1 rd(1, 24'h10_0050, 32'h0000_0002);
        rd(0, 24'h10_0130, 32'h0000_0002);
        rd(1, 24'h10_023c, 32'h0000_0004);
        rd(0, 24'h10_035c, 32'h0000_0010);
        rd(1, 24'h10_0134, 32'h0000_0615);
        rd(0, 24'h10_0138, 32'h0000_0595);
        rd(1, 24'h10_0054, 32'h0000_0015);
        rd(0, 24'h10_0058, 32'h0000_0015);
        rd(1, 24'h10_0364, 32'h0000_0000);
        rd(0, 24'h10_0000, 32'h0000_0000);
        rd(0, 24'h10_0224, cncfg_pkg::PART_CODE_VAL);
        rd(0, 24'h10_0368, 32'h0000_0000);
        rd(1, 24'h10_0240, {30'h0, cncfg_pkg::DEFAULT_LINK_RST, 1'b0});
        $display("Reset values done");
        acc(0, 1, 24'h10_0244, 32'hffff_ff5a);
        rd(1, 24'h10_0244, 32'h0000_005a);
        acc(1, 1, 24'h10_0248, 32'h0000_0007);
        rd(0, 24'h10_0248, 32'h0000_0007);
        acc(1, 1, 24'h10_0360, 32'h0000_0000);
        rd(0, 24'h10_0360, {18'h0, 1'b1, cncfg_pkg::RESYNC_JUMP_RST,
            cncfg_pkg::PHASE_SEG_TWO_RST, cncfg_pkg::PHASE_SEG_ONE_RST,
            cncfg_pkg::BIT_PRESCALER_RST});
        acc(0, 1, 24'h10_0360, 32'hffff_d555);
        rd(1, 24'h10_0360, 32'h0000_1555);
        $display("Writable fields done");
        repeat (3) pulse(lsw);
        rd(0, 24'h10_024c, 32'h0000_0003);
        rd(1, 24'h10_024c, 32'h0000_0000);
        pulse(lsw);
        acc(1, 1, 24'h10_024c, 32'h0000_00aa);
        rd(0, 24'h10_024c, 32'h0000_0000);
        $display("Read-clear done");
        for (int k = 0; k < 8; k++) begin
            kind = cncfg_pkg::cncfg_abort_e'(k);
            pulse(fault);
            repeat (2) @(posedge clk);
            #1 rd(k[0], 24'h10_0368, codes[k]);
        end
        arc = 32'h0604_0041;
        pulse(arx);
        repeat (2) @(posedge clk);
        #1 rd(1, 24'h10_0368, 32'h0604_0041);
        $display("Abort codes done");
        rxs = 8'h05;
        txs = 8'h90;
        nst = cncfg_pkg::CNCFG_ST_OPER;
        pulse(nset);
        repeat (3) @(posedge clk);
        #1 rd(1, 24'h10_0364, 32'h9005_0210);
        pulse(qov);
        rd(0, 24'h10_0364, 32'h9005_0290);
        chk({31'h0, cerr}, 32'h0000_0001);
        acc(0, 1, 24'h10_0364, 32'h0000_0080);
        rd(1, 24'h10_0364, 32'h9005_0210);
        $display("Status done");
        end_sim();
    end
endmodule
`default_nettype wire
